/* ssc_regs.svh */
// constants for the sensor system command unit
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

`define SSC_CODE_READ_REG 8'h01
`define SSC_CODE_WRITE_NV 8'h03
`define SSC_CODE_RESTORE 8'h04
`define SSC_CODE_ZERO 8'h05
`define SSC_CODE_RESET 8'h06
`define SSC_CODE_MAG 8'h08
`define SSC_CODE_ACCEL 8'h09
`define SSC_CODE_BIAS 8'h0b
`define SSC_RSP_LEAD 8'h00

`define SSC_ERR_HARD_FAULT 4'd1
`define SSC_ERR_IN_OVERFLOW 4'd2
`define SSC_ERR_CHECKSUM 4'd3
`define SSC_ERR_BAD_CMD 4'd4
`define SSC_ERR_FEW_PARAMS 4'd5
`define SSC_ERR_MANY_PARAMS 4'd6
`define SSC_ERR_BAD_PARAM 4'd7
`define SSC_ERR_BAD_REG 4'd8
`define SSC_ERR_DENIED 4'd9
`define SSC_ERR_WATCHDOG 4'd10
`define SSC_ERR_OUT_OVERFLOW 4'd11
`define SSC_ERR_BAUD_LOW 4'd12
`define SSC_ERR_NONE 4'd0

`define SSC_CLK_MHZ 50
`define SSC_SPI_GAP_US 50
`define SSC_SPI_GAP_CYCLES (`SSC_SPI_GAP_US * `SSC_CLK_MHZ)
`define SSC_RESTART_MS 50
`define SSC_RESTART_CYCLES (`SSC_RESTART_MS * 1000 * `SSC_CLK_MHZ)
`define SSC_IN_BUF_CHARS 256
`define SSC_OUT_BUF_CHARS 2048

`endif

/* ssc_pkg.sv */
// types for the sensor system command unit
package ssc_pkg;
  typedef enum logic [2:0] {
    ssc_op_none, ssc_op_fwd, ssc_op_restore, ssc_op_zero,
    ssc_op_reset, ssc_op_mag, ssc_op_accel, ssc_op_bias
  } ssc_op_t;
  typedef enum logic [2:0] {
    ssc_st_boot, ssc_st_idle, ssc_st_gap, ssc_st_defaults, ssc_st_reset
  } ssc_state_t;
endpackage

/* ssc_dec_if.sv */
// decoder carrier between top and frame classifier
`timescale 1ns/1ps
`default_nettype none
interface ssc_dec_if;
  import ssc_pkg::*;
  logic [63:0] frame;
  logic [3:0] nparams;
  logic crc_bad;
  ssc_op_t op;
  logic [3:0] err;
  logic flag;
  modport dec (input frame, input nparams, input crc_bad, output op, output err, output flag);
  modport user (output frame, output nparams, output crc_bad, input op, input err, input flag);
endinterface
`default_nettype wire

/* ssc_decode.sv */
// classifies one command frame into an operation or an error code
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.svh"
module ssc_decode
  import ssc_pkg::*;
(
  ssc_dec_if.dec d
);
  logic [7:0] code;
  logic [7:0] arg;
  logic [3:0] need;
  always_comb begin
    code = d.frame[63:56];
    arg = d.frame[55:48];
    need = 4'd0;
    d.op = ssc_op_none;
    d.err = `SSC_ERR_NONE;
    d.flag = arg[0];
    unique case (code)
      `SSC_CODE_RESTORE: d.op = ssc_op_restore;
      `SSC_CODE_ZERO: d.op = ssc_op_zero;
      `SSC_CODE_RESET: d.op = ssc_op_reset;
      `SSC_CODE_BIAS: d.op = ssc_op_bias;
      `SSC_CODE_MAG: begin
        d.op = ssc_op_mag;
        need = 4'd1;
      end
      `SSC_CODE_ACCEL: begin
        d.op = ssc_op_accel;
        need = 4'd1;
      end
      default: begin
        if (code >= `SSC_CODE_READ_REG && code <= `SSC_CODE_WRITE_NV) begin
          d.op = ssc_op_fwd;
        end else begin
          d.err = `SSC_ERR_BAD_CMD;
        end
      end
    endcase
    if (d.op != ssc_op_fwd && d.op != ssc_op_none) begin
      if (d.nparams < need) begin
        d.err = `SSC_ERR_FEW_PARAMS;
      end else if (d.nparams > need) begin
        d.err = `SSC_ERR_MANY_PARAMS;
      end else if (need == 4'd1 && arg > 8'h01) begin
        d.err = `SSC_ERR_BAD_PARAM;
      end
    end
    if (d.crc_bad) begin
      d.err = `SSC_ERR_CHECKSUM;
    end
    if (d.err != `SSC_ERR_NONE) begin
      d.op = ssc_op_none;
    end
  end
endmodule
`default_nettype wire

/* ssc_timer.sv */
// loadable down counter with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module ssc_timer #(
  parameter int WIDTH = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [WIDTH-1:0] count,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic next_done;
  if (WIDTH < 2) begin : g_chk
    $error("ssc_timer WIDTH too small");
  end
  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (start) begin
      next_cnt = count;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_done = (cnt == WIDTH'(1));
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end
  assign busy = (cnt != '0);
endmodule
`default_nettype wire

/* ssc_top.sv */
// system command unit: decodes, answers, reports errors and sequences resets
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.svh"
module ssc_top
  import ssc_pkg::*;
#(
  parameter int GAP_CYCLES = `SSC_SPI_GAP_CYCLES,
  parameter int RESTART_CYCLES = `SSC_RESTART_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [63:0] cmd_frame,
  input wire logic [3:0] cmd_nparams,
  input wire logic cmd_crc_bad,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [63:0] rsp_frame,
  output logic fwd_valid,
  output logic [63:0] fwd_frame,
  input wire logic evt_hard_fault,
  input wire logic evt_in_overflow,
  input wire logic evt_reg_invalid,
  input wire logic evt_reg_denied,
  input wire logic evt_fatal,
  input wire logic evt_out_overflow,
  input wire logic evt_baud_low,
  output logic err_valid,
  output logic [3:0] err_code,
  input wire logic mag_mode_3d,
  input wire logic mag_cal_enabled,
  input wire logic nvm_saved,
  input wire logic nvm_bias_saved,
  output logic zero_heading,
  output logic zero_tilt,
  output logic capture_align,
  output logic mag_disturbed,
  output logic mag_cal_pause,
  output logic accel_disturbed,
  output logic store_bias,
  output logic load_defaults,
  output logic reload_nvm,
  output logic bias_from_store,
  output logic estimator_reinit,
  output logic sys_reset_req
);
  localparam int GAP_W = 12;
  localparam int RST_W = 22;

  if (GAP_CYCLES < 1 || GAP_CYCLES >= (1 << GAP_W)) begin : g_gap_chk
    $error("GAP_CYCLES out of range");
  end
  if (RESTART_CYCLES < 1 || RESTART_CYCLES >= (1 << RST_W)) begin : g_rst_chk
    $error("RESTART_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // lowest pending error code first

  function automatic logic [3:0] ssc_lowest(input logic [12:1] v);
    logic [3:0] r;
    r = `SSC_ERR_NONE;
    for (int i = 12; i >= 1; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // frame decode and timers

  ssc_dec_if dif ();
  assign dif.frame = cmd_frame;
  assign dif.nparams = cmd_nparams;
  assign dif.crc_bad = cmd_crc_bad;

  ssc_decode u_decode (
    .d(dif.dec)
  );

  logic gap_start;
  logic gap_busy;
  logic gap_done;
  logic wd_start;
  logic wd_busy;
  logic wd_done;

  ssc_timer #(.WIDTH(GAP_W)) u_gap (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(gap_start),
    .count(GAP_W'(GAP_CYCLES)),
    .busy(gap_busy),
    .done(gap_done)
  );

  ssc_timer #(.WIDTH(RST_W)) u_wdog (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(wd_start),
    .count(RST_W'(RESTART_CYCLES)),
    .busy(wd_busy),
    .done(wd_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // state

  ssc_state_t state, next_state;
  logic [12:1] pend, next_pend;
  logic wd_reason, next_wd_reason;
  logic next_cmd_ready;
  logic next_rsp_valid;
  logic [63:0] next_rsp_frame;
  logic next_fwd_valid;
  logic [63:0] next_fwd_frame;
  logic next_err_valid;
  logic [3:0] next_err_code;
  logic next_zero_heading, next_zero_tilt, next_capture_align;
  logic next_mag_disturbed, next_mag_cal_pause, next_accel_disturbed;
  logic next_store_bias, next_load_defaults, next_reload_nvm;
  logic next_bias_from_store, next_estimator_reinit, next_sys_reset_req;
  logic take;
  logic [3:0] grant;

  always_comb begin
    take = cmd_valid && cmd_ready;
    next_state = state;
    next_pend = pend;
    next_wd_reason = wd_reason;
    next_rsp_valid = 1'b0;
    next_rsp_frame = rsp_frame;
    next_fwd_valid = 1'b0;
    next_fwd_frame = fwd_frame;
    next_err_valid = 1'b0;
    next_err_code = err_code;
    next_zero_heading = 1'b0;
    next_zero_tilt = 1'b0;
    next_capture_align = 1'b0;
    next_mag_disturbed = mag_disturbed;
    next_accel_disturbed = accel_disturbed;
    next_store_bias = 1'b0;
    next_load_defaults = 1'b0;
    next_reload_nvm = 1'b0;
    next_bias_from_store = bias_from_store;
    next_estimator_reinit = 1'b0;
    next_sys_reset_req = 1'b0;
    gap_start = 1'b0;
    wd_start = 1'b0;

    // one report per cycle, lowest code first; new events below win over this clear
    grant = ssc_lowest(pend);
    if (grant != `SSC_ERR_NONE) begin
      next_pend[grant] = 1'b0;
      next_err_valid = 1'b1;
      next_err_code = grant;
    end

    unique case (state)
      ssc_st_boot: begin
        // reload saved settings, else factory defaults, and restart the estimator
        next_reload_nvm = nvm_saved;
        next_load_defaults = !nvm_saved;
        next_bias_from_store = nvm_saved && nvm_bias_saved;
        next_estimator_reinit = 1'b1;
        // a spacing gap still running from the last command is served out first
        next_state = gap_busy ? ssc_st_gap : ssc_st_idle;
      end
      ssc_st_idle: begin
        if (take) begin
          gap_start = 1'b1;
          next_state = ssc_st_gap;
          if (dif.err != `SSC_ERR_NONE) begin
            next_pend[dif.err] = 1'b1;
          end else if (dif.op == ssc_op_fwd) begin
            next_fwd_valid = 1'b1;
            next_fwd_frame = cmd_frame;
          end else begin
            next_rsp_valid = 1'b1;
            next_rsp_frame = {`SSC_RSP_LEAD, cmd_frame[63:8]};
            unique case (dif.op)
              ssc_op_restore: next_state = ssc_st_defaults;
              ssc_op_reset: next_state = ssc_st_reset;
              ssc_op_zero: begin
                next_zero_heading = 1'b1;
                next_zero_tilt = mag_mode_3d;
                next_capture_align = mag_mode_3d;
              end
              ssc_op_mag: next_mag_disturbed = dif.flag;
              ssc_op_accel: next_accel_disturbed = dif.flag;
              ssc_op_bias: next_store_bias = 1'b1;
              default: next_state = ssc_st_gap;
            endcase
          end
        end
      end
      ssc_st_gap: begin
        if (gap_done) begin
          next_state = ssc_st_idle;
        end
      end
      ssc_st_defaults: begin
        // answer already out; now factory defaults, then reset
        next_load_defaults = 1'b1;
        next_state = ssc_st_reset;
      end
      ssc_st_reset: begin
        // unlike a pin reset, only the disturbance flags, rsp_frame and wd_reason are cleared, then boot
        next_sys_reset_req = 1'b1;
        next_mag_disturbed = 1'b0;
        next_accel_disturbed = 1'b0;
        next_rsp_frame = '0;
        next_state = ssc_st_boot;
        if (wd_reason) begin
          next_pend[`SSC_ERR_WATCHDOG] = 1'b1;
          next_wd_reason = 1'b0;
        end
      end
    endcase

    // fault handling: restart within the bound, watchdog code after the restart only if evt_fatal was seen
    if (evt_hard_fault) begin
      next_pend[`SSC_ERR_HARD_FAULT] = 1'b1;
    end
    if ((evt_hard_fault || evt_fatal) && !wd_busy) begin
      wd_start = 1'b1;
    end
    if (evt_fatal) begin
      next_wd_reason = 1'b1;
    end
    if (wd_done) begin
      next_state = ssc_st_reset;
    end

    if (evt_in_overflow) begin
      next_pend[`SSC_ERR_IN_OVERFLOW] = 1'b1;
    end
    if (evt_reg_invalid) begin
      next_pend[`SSC_ERR_BAD_REG] = 1'b1;
    end
    if (evt_reg_denied) begin
      next_pend[`SSC_ERR_DENIED] = 1'b1;
    end
    if (evt_out_overflow) begin
      next_pend[`SSC_ERR_OUT_OVERFLOW] = 1'b1;
    end
    if (evt_baud_low) begin
      next_pend[`SSC_ERR_BAUD_LOW] = 1'b1;
    end

    next_mag_cal_pause = next_mag_disturbed && mag_cal_enabled;
    next_cmd_ready = (next_state == ssc_st_idle);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ssc_st_boot;
      pend <= '0;
      wd_reason <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_frame <= '0;
      fwd_valid <= 1'b0;
      fwd_frame <= '0;
      err_valid <= 1'b0;
      err_code <= `SSC_ERR_NONE;
      zero_heading <= 1'b0;
      zero_tilt <= 1'b0;
      capture_align <= 1'b0;
      mag_disturbed <= 1'b0;
      mag_cal_pause <= 1'b0;
      accel_disturbed <= 1'b0;
      store_bias <= 1'b0;
      load_defaults <= 1'b0;
      reload_nvm <= 1'b0;
      bias_from_store <= 1'b0;
      estimator_reinit <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      state <= next_state;
      pend <= next_pend;
      wd_reason <= next_wd_reason;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_frame <= next_rsp_frame;
      fwd_valid <= next_fwd_valid;
      fwd_frame <= next_fwd_frame;
      err_valid <= next_err_valid;
      err_code <= next_err_code;
      zero_heading <= next_zero_heading;
      zero_tilt <= next_zero_tilt;
      capture_align <= next_capture_align;
      mag_disturbed <= next_mag_disturbed;
      mag_cal_pause <= next_mag_cal_pause;
      accel_disturbed <= next_accel_disturbed;
      store_bias <= next_store_bias;
      load_defaults <= next_load_defaults;
      reload_nvm <= next_reload_nvm;
      bias_from_store <= next_bias_from_store;
      estimator_reinit <= next_estimator_reinit;
      sys_reset_req <= next_sys_reset_req;
    end
  end
endmodule
`default_nettype wire

/* ssc_top_asserts.sv */
// concurrent checks on the ports of the system command unit
`timescale 1ns/1ps
`default_nettype none
module ssc_top_checker #(
  parameter int GAP_CYCLES = 2500,
  parameter int RESTART_CYCLES = 2500000
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [63:0] cmd_frame,
  input wire logic [3:0] cmd_nparams,
  input wire logic cmd_crc_bad,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [63:0] rsp_frame,
  input wire logic fwd_valid,
  input wire logic err_valid,
  input wire logic [3:0] err_code,
  input wire logic mag_mode_3d,
  input wire logic zero_heading,
  input wire logic zero_tilt,
  input wire logic capture_align,
  input wire logic mag_disturbed,
  input wire logic accel_disturbed,
  input wire logic load_defaults,
  input wire logic sys_reset_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic ok;
  logic one;
  logic [7:0] code;
  logic [63:0] held;
  logic [63:0] next_held;
  assign take = cmd_valid && cmd_ready;
  assign ok = take && !cmd_crc_bad;
  assign code = cmd_frame[63:56];
  assign one = ok && cmd_nparams == 4'h1 && cmd_frame[55:49] == 7'h00;
  always_comb begin
    next_held = take ? cmd_frame : held;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 64'h0;
    end else begin
      held <= next_held;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_rsp_echo: assert property (rsp_valid |-> rsp_frame == {8'h00, held[63:8]})
    else $error("answer frame does not echo the command");
  a_gap_refuse: assert property (take |=> !cmd_ready [*8])
    else $error("command taken inside the spacing gap");
  a_one_answer: assert property (take |=> ##[0:12] (rsp_valid || fwd_valid || err_valid))
    else $error("command left without any answer");
  a_restore_seq: assert property (ok && code == 8'h04 && cmd_nparams == 4'h0
    |=> rsp_valid ##1 load_defaults ##1 sys_reset_req)
    else $error("restore sequence out of order");
  a_reset_seq: assert property (ok && code == 8'h06 && cmd_nparams == 4'h0
    |=> rsp_valid ##1 sys_reset_req)
    else $error("soft reset not after its answer");
  a_zero_axes: assert property (ok && code == 8'h05 && cmd_nparams == 4'h0 |=> zero_heading
    && zero_tilt == $past(mag_mode_3d) && capture_align == $past(mag_mode_3d))
    else $error("zeroing touched the wrong angles");
  a_crc_err: assert property (take && cmd_crc_bad |=> ##[0:12] (err_valid && err_code == 4'd3))
    else $error("checksum failure not reported");
  a_bad_param: assert property (ok && (code == 8'h08 || code == 8'h09) && cmd_nparams == 4'h1
    && cmd_frame[55:48] > 8'h01 |=> !rsp_valid && $stable(mag_disturbed) && $stable(accel_disturbed))
    else $error("bad disturbance value changed state");
  a_mag_flag: assert property (one && code == 8'h08 |=> ##1 mag_disturbed == held[48])
    else $error("magnetic flag does not follow command");
  a_accel_flag: assert property (one && code == 8'h09 |=> ##1 accel_disturbed == held[48])
    else $error("acceleration flag does not follow command");
  a_err_range: assert property (err_valid |-> err_code >= 4'd1 && err_code <= 4'd12)
    else $error("error code out of range");
  c_zero_3d: cover property (ok && code == 8'h05 && mag_mode_3d);
  c_watchdog: cover property (err_valid && err_code == 4'd10);
  c_restart: cover property (sys_reset_req);
endmodule
bind ssc_top ssc_top_checker #(.GAP_CYCLES(GAP_CYCLES), .RESTART_CYCLES(RESTART_CYCLES)) u_checker (.*);
`default_nettype wire

/* ssc_host_model.sv */
// host controller that offers command frames and holds them until taken or lim cycles pass
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model (
  input wire logic sys_clk,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic [63:0] cmd_frame,
  output logic [3:0] cmd_nparams,
  output logic cmd_crc_bad
);
  initial begin
    cmd_valid = 1'b0;
    cmd_frame = 64'h0;
    cmd_nparams = 4'h0;
    cmd_crc_bad = 1'b0;
  end
  task automatic send(input logic [63:0] f, input logic [3:0] np, input logic bad, input int lim);
    int n;
    n = 0;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_frame <= f;
    cmd_nparams <= np;
    cmd_crc_bad <= bad;
    @(posedge sys_clk);
    while (cmd_ready !== 1'b1 && n < lim) begin
      n++;
      @(posedge sys_clk);
    end
    cmd_valid <= 1'b0;
    cmd_frame <= ~f;
    cmd_nparams <= ~np;
    cmd_crc_bad <= ~bad;
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the system command unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, rst_n, cmd_valid, cmd_crc_bad, cmd_ready, rsp_valid, fwd_valid, err_valid;
  logic [63:0] cmd_frame, rsp_frame, fwd_frame;
  logic [3:0] cmd_nparams, err_code;
  logic [6:0] evt;
  logic mag_mode_3d, mag_cal_enabled, nvm_saved, nvm_bias_saved, zero_heading, zero_tilt, capture_align;
  logic mag_disturbed, mag_cal_pause, accel_disturbed, store_bias, load_defaults, reload_nvm;
  logic bias_from_store, estimator_reinit, sys_reset_req, md, ad;
  logic [31:0] seed = 32'h6b809367;
  logic [31:0] r;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [23:0] tbl [13] = '{24'h000500, 24'h010801, 24'h010800, 24'h010901, 24'h010900,
    24'h000b00, 24'h010802, 24'h000700, 24'h100500, 24'h000800, 24'h010500, 24'h000105, 24'h020901};
  ssc_top #(.GAP_CYCLES(20), .RESTART_CYCLES(40)) DUT (.*, .evt_hard_fault(evt[0]),
    .evt_in_overflow(evt[1]), .evt_reg_invalid(evt[2]), .evt_reg_denied(evt[3]),
    .evt_fatal(evt[4]), .evt_out_overflow(evt[5]), .evt_baud_low(evt[6]));
  ssc_host_model host (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
    .cmd_frame(cmd_frame), .cmd_nparams(cmd_nparams), .cmd_crc_bad(cmd_crc_bad));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] exp_err(logic [63:0] f, logic [3:0] np, logic bad);
    logic [7:0] c;
    logic [3:0] need;
    c = f[63:56];
    need = (c == 8'h08 || c == 8'h09) ? 4'h1 : 4'h0;
    if (bad) return 4'd3;
    if (!(c inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0b})) return 4'd4;
    if (np < need) return 4'd5;
    if (np > need) return 4'd6;
    if (need == 4'h1 && f[55:48] > 8'h01) return 4'd7;
    return 4'd0;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic boot_chk();
    chk(reload_nvm, nvm_saved);
    chk(load_defaults, !nvm_saved);
    chk(estimator_reinit, 1'b1);
    @(posedge sys_clk); #1;
    chk(bias_from_store, nvm_saved & nvm_bias_saved);
    md = 1'b0;
    ad = 1'b0;
  endtask
  task automatic run_cmd(input logic [23:0] e);
    logic [63:0] f;
    logic [3:0] ee;
    logic [7:0] c;
    f = {e[15:0], 48'h0};
    c = e[15:8];
    ee = exp_err(f, e[19:16], e[20]);
    r = rnd();
    @(posedge sys_clk);
    mag_cal_enabled <= r[3];
    host.send(f, e[19:16], e[20], 200);
    #1;
    if (ee != 4'd0) begin
      @(posedge sys_clk); #1;
      chk(err_valid, 1'b1);
      chk(err_code, ee);
    end else if (c < 8'h04) begin
      chk(fwd_valid, 1'b1);
      chk(fwd_frame, f);
    end else begin
      chk(rsp_valid, 1'b1);
      chk(rsp_frame, {8'h00, f[63:8]});
      chk({zero_heading, zero_tilt, capture_align, store_bias},
        {c == 8'h05, {2{c == 8'h05 && mag_mode_3d}}, c == 8'h0b});
      if (c == 8'h08) md = e[0];
      if (c == 8'h09) ad = e[0];
    end
    @(posedge sys_clk); #1;
    chk({mag_disturbed, accel_disturbed, mag_cal_pause}, {md, ad, md & mag_cal_enabled});
  endtask
  task automatic run_reset(input logic [7:0] c);
    host.send({c, 56'h0}, 4'h0, 1'b0, 200);
    #1;
    chk(rsp_valid, 1'b1);
    chk(rsp_frame, {8'h00, c, 48'h0});
    if (c == 8'h04) begin
      @(posedge sys_clk); #1;
      chk(load_defaults, 1'b1);
    end
    @(posedge sys_clk); #1;
    chk(sys_reset_req, 1'b1);
    @(posedge sys_clk); #1;
    boot_chk();
  endtask
  task automatic wait_for(input bit rst_sig);
    int n;
    n = 0;
    @(posedge sys_clk); #1;
    while ((rst_sig ? sys_reset_req : err_valid) !== 1'b1 && n < 200) begin
      n++;
      @(posedge sys_clk); #1;
    end
    chk(n < 200, 1'b1);
  endtask
  task automatic fire(input logic [6:0] v, input logic [3:0] code);
    @(posedge sys_clk);
    evt <= v;
    @(posedge sys_clk);
    evt <= 7'h0;
    wait_for(1'b0);
    chk(err_code, code);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    evt = 7'h0;
    mag_mode_3d = 1'b0;
    mag_cal_enabled = 1'b0;
    nvm_saved = 1'b0;
    nvm_bias_saved = 1'b0;
    for (int p = 0; p < 2; p++) begin
      r = rnd();
      @(posedge sys_clk);
      rst_n <= 1'b0;
      mag_mode_3d <= r[0] ^ p[0]; // mode settled before reset, then zeroing
      nvm_saved <= r[1];
      nvm_bias_saved <= r[2];
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk); #1;
      boot_chk();
      foreach (tbl[i]) run_cmd(tbl[i]); // bias store with the sensor still
      repeat (12) begin
        r = rnd();
        run_cmd(tbl[r % 13]);
      end
    end
    run_reset(8'h04);
    run_reset(8'h06);
    fire(7'h02, 4'd2);
    fire(7'h04, 4'd8);
    fire(7'h08, 4'd9);
    fire(7'h20, 4'd11);
    fire(7'h40, 4'd12);
    fire(7'h22, 4'd2);
    @(posedge sys_clk); #1;
    chk({err_valid, err_code}, {1'b1, 4'd11});
    fire(7'h01, 4'd1);
    wait_for(1'b1);
    @(posedge sys_clk);
    evt <= 7'h10;
    @(posedge sys_clk);
    evt <= 7'h0;
    wait_for(1'b1);
    wait_for(1'b0);
    chk(err_code, 4'd10);
    complete_run();
  end
endmodule
`default_nettype wire
